//--- rtl/swc_params.svh
// Timing counts and encodings for the sleep and wake-up controller
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH

`define SWC_OSC_STARTUP_TOSC   1024
`define SWC_OSC_STARTUP_CYCLES 11'h400
`define SWC_CNT_W              11
`define SWC_PC_W               13
`define SWC_IRQ_VECTOR         13'h0004
`define SWC_PC_STEP            13'h0001
`define SWC_OSC_MODE_W         2
`define SWC_OSC_LP             2'h0
`define SWC_OSC_XT             2'h1
`define SWC_OSC_HS             2'h2
`define SWC_OSC_RC             2'h3
`define SWC_NUM_SRC            3
`define SWC_PORT_W             13

`endif

//--- rtl/swc_pkg.sv
// Types shared by the sleep and wake-up controller
package swc_pkg;

	typedef enum logic [3:0] {
		SWC_RUN     = 4'h1,
		SWC_SLEEP   = 4'h2,
		SWC_STARTUP = 4'h4,
		SWC_RESUME  = 4'h8
	} swc_state_e;

	typedef struct packed {
		logic [2:0] enable;
		logic [2:0] flag;
	} swc_irq_s;

	typedef struct packed {
		logic [12:0] drive;
		logic [12:0] oe;
	} swc_port_s;

endpackage : swc_pkg

//--- rtl/swc_sleep_wakeup_control.sv
// Power-down entry and wake-up control
// Notes on behaviour
// (R1) Sleep instruction enters power-down
// (R2) Entry clears watchdog, power-down flag, stops oscillator
// (R3) Ports hold their pre-sleep drive state
// (R4) Watchdog reset never drives master reset low
// (R5) Wake on reset pin, watchdog, enabled interrupt
// (R6) Pin resets device; others continue execution
// (R7) Watchdog wake clears time-out flag
// (R8) Power-down flag set at power-up, cleared on sleep
// (R9) Next address prefetched during sleep instruction
// (R10) Source enable needed; global enable ignored
// (R11) Global disabled: resume at following instruction
// (R12) Global enabled: run next, then vector
// (R13) Software may place no-op after sleep
// (R14) Pending enabled interrupt wakes immediately
// (R15) Watchdog cleared on every wake-up; here a reset-pin wake gives no watchdog_clear pulse
// (R16) Crystal modes wait start-up delay; RC none
// (R17) Execution held until oscillator ready
`include "swc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module swc_sleep_wakeup_control (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// Core side
	input  wire logic                          sleep_exec,
	input  wire logic [`SWC_PC_W-1:0]          pc,
	input  wire logic                          global_irq_enable,
	input  wire swc_pkg::swc_irq_s             irq,
	input  wire logic [1:0]                    osc_mode,
	input  wire logic                          clrwdt_exec,
	// Outside pins and watchdog
	input  wire logic                          master_reset_pin_n,
	input  wire logic                          watchdog_enable,
	input  wire logic                          watchdog_timeout,
	input  wire swc_pkg::swc_port_s            port_in,
	// Outputs
	output logic                               power_down_flag,
	output logic                               timeout_flag,
	output logic                               osc_driver_on,
	output logic                               watchdog_clear,
	output logic                               core_hold,
	output logic                               device_reset,
	output logic                               master_reset_drive_n,
	output logic                               prefetch_req,
	output logic [`SWC_PC_W-1:0]               prefetch_addr,
	output logic                               vector_req,
	output logic [`SWC_PC_W-1:0]               vector_addr,
	output swc_pkg::swc_port_s                 port_out
);

	swc_pkg::swc_state_e           state_reg;
	logic [`SWC_CNT_W-1:0]         cnt_reg;
	logic                          master_reset_pin_meta_reg;
	logic                          master_reset_pin_sync_reg;
	logic                          wdt_meta_reg;
	logic                          wdt_sync_reg;
	logic                          irq_wake_reg;
	logic                          gie_at_wake_reg;

	function automatic logic irq_pending(input swc_pkg::swc_irq_s s);
		irq_pending = |(s.enable & s.flag); // [R10]
	endfunction : irq_pending

	function automatic logic needs_startup(input logic [1:0] m);
		needs_startup = (m != `SWC_OSC_RC); // [R16]
	endfunction : needs_startup

	// Pin and watchdog lines come from outside this clock's domain
	always_ff @(posedge clk) begin
		if (!nrst) begin
			master_reset_pin_meta_reg <= 1'b1;
			master_reset_pin_sync_reg <= 1'b1;
			wdt_meta_reg  <= 1'b0;
			wdt_sync_reg  <= 1'b0;
		end else begin
			master_reset_pin_meta_reg <= master_reset_pin_n;
			master_reset_pin_sync_reg <= master_reset_pin_meta_reg;
			wdt_meta_reg  <= watchdog_timeout;
			wdt_sync_reg  <= wdt_meta_reg;
		end
	end

	logic wdt_wake;
	logic irq_wake;
	logic pin_reset;
	assign pin_reset = !master_reset_pin_sync_reg;
	assign wdt_wake  = wdt_sync_reg && watchdog_enable; // [R5]
	assign irq_wake  = irq_pending(irq); // [R5] [R10]

	logic sleep_entry;
	logic wake_event;
	// A reset pin already in force wins over a sleep request or a wake in that cycle
	assign sleep_entry = state_reg == swc_pkg::SWC_RUN && sleep_exec && !pin_reset; // [R1]
	assign wake_event  = state_reg == swc_pkg::SWC_SLEEP && (wdt_wake || irq_wake) && !pin_reset; // [R5] [R15]

	// Sequencer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg       <= swc_pkg::SWC_RUN;
			cnt_reg         <= '0;
			irq_wake_reg    <= 1'b0;
			gie_at_wake_reg <= 1'b0;
		end else if (pin_reset) begin
			state_reg       <= swc_pkg::SWC_RUN; // [R6]
			cnt_reg         <= '0;
			irq_wake_reg    <= 1'b0;
			gie_at_wake_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				swc_pkg::SWC_RUN: begin
					// Sleep completes unless the reset pin is in force, even with a wake already pending
					if (sleep_exec)
						state_reg <= swc_pkg::SWC_SLEEP; // [R1] [R14]
				end
				swc_pkg::SWC_SLEEP: begin
					if (wdt_wake || irq_wake) begin // [R5]
						irq_wake_reg    <= irq_wake && !wdt_wake;
						gie_at_wake_reg <= global_irq_enable; // [R10]
						cnt_reg         <= needs_startup(osc_mode) ? `SWC_OSC_STARTUP_CYCLES : '0;
						state_reg       <= swc_pkg::SWC_STARTUP;
					end
				end
				swc_pkg::SWC_STARTUP: begin
					if (cnt_reg == '0)
						state_reg <= swc_pkg::SWC_RESUME; // [R17]
					else
						cnt_reg <= cnt_reg - 1'b1; // [R16]
				end
				swc_pkg::SWC_RESUME: begin
					state_reg <= swc_pkg::SWC_RUN; // [R6]
				end
				default: state_reg <= swc_pkg::SWC_RUN;
			endcase
		end
	end

	// Power-down flag; a power-up reset sets it
	always_ff @(posedge clk) begin
		if (!nrst)
			power_down_flag <= 1'b1; // [R8]
		else if (sleep_entry)
			power_down_flag <= 1'b0; // [R2] [R8]
		else if (clrwdt_exec && state_reg == swc_pkg::SWC_RUN)
			power_down_flag <= 1'b1;
	end

	// Time-out flag; only a watchdog wake clears it, so software can tell the cause
	always_ff @(posedge clk) begin
		if (!nrst)
			timeout_flag <= 1'b1;
		else if (sleep_entry || (clrwdt_exec && state_reg == swc_pkg::SWC_RUN))
			timeout_flag <= 1'b1; // [R2]
		else if (state_reg == swc_pkg::SWC_SLEEP && wdt_wake && !pin_reset)
			timeout_flag <= 1'b0; // [R7]
	end

	// Oscillator, watchdog clear and core hold
	always_ff @(posedge clk) begin
		if (!nrst) begin
			osc_driver_on  <= 1'b1;
			watchdog_clear <= 1'b0;
			core_hold      <= 1'b0;
		end else begin
			// Oscillator is off for all of sleep and the first start-up cycle; it is on after that
			osc_driver_on  <= !sleep_entry && state_reg != swc_pkg::SWC_SLEEP; // [R2] [R16]
			watchdog_clear <= sleep_entry || wake_event; // [R2] [R15]
			// Hold spans start-up so the core never fetches on an unsettled clock
			core_hold      <= sleep_entry
				|| state_reg == swc_pkg::SWC_SLEEP
				|| state_reg == swc_pkg::SWC_STARTUP; // [R17]
		end
	end

	// Reset outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			device_reset         <= 1'b0;
			master_reset_drive_n <= 1'b1;
		end else begin
			device_reset         <= pin_reset; // [R6]
			// Pin is only ever an input here; a watchdog reset stays internal
			master_reset_drive_n <= 1'b1; // [R4]
		end
	end

	// Prefetch of the instruction after sleep
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prefetch_req  <= 1'b0;
			prefetch_addr <= '0;
		end else begin
			prefetch_req <= sleep_entry; // [R9]
			if (sleep_entry)
				prefetch_addr <= pc + `SWC_PC_STEP; // [R9] [R11]
		end
	end

	// Vectoring after an interrupt wake
	always_ff @(posedge clk) begin
		if (!nrst) begin
			vector_req  <= 1'b0;
			vector_addr <= `SWC_IRQ_VECTOR;
		end else begin
			// Prefetched instruction runs first, then the core takes the vector
			vector_req  <= state_reg == swc_pkg::SWC_RESUME && irq_wake_reg && gie_at_wake_reg
				&& !pin_reset; // [R12]
			vector_addr <= `SWC_IRQ_VECTOR; // [R12]
		end
	end

	// Port latch frozen while asleep
	always_ff @(posedge clk) begin
		if (!nrst)
			port_out <= '0;
		else if (state_reg == swc_pkg::SWC_RUN && !sleep_exec)
			port_out <= port_in; // [R3]
	end

endmodule : swc_sleep_wakeup_control

`default_nettype wire

//--- verif/swc_wdog_model.sv
// Watchdog stand-in giving a four-cycle time-out per request
`timescale 1ns/10ps
`default_nettype none
module swc_wdog_model (
	// Clock and request
	input  wire logic clk,
	input  wire logic fire,
	// Time-out towards the block
	output logic      watchdog_timeout
);
	logic [2:0] cnt_reg;
	// Four cycles outlast the two that the synchroniser needs
	always_ff @(posedge clk) cnt_reg <= !fire ? 3'h0 : cnt_reg + {2'h0, cnt_reg != 3'h5};
	assign watchdog_timeout = fire && cnt_reg inside {[3'h1 : 3'h4]};
endmodule : swc_wdog_model
`default_nettype wire

//--- verif/swc_sleep_wakeup_control_props.sv
// Checker for the sleep and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module swc_props (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// Core side inputs
	input  wire logic               sleep_exec,
	input  wire logic [1:0]         osc_mode,
	input  wire logic [12:0]        pc,
	// Block outputs
	input  wire logic               power_down_flag,
	input  wire logic               timeout_flag,
	input  wire logic               osc_driver_on,
	input  wire logic               watchdog_clear,
	input  wire logic               core_hold,
	input  wire logic               device_reset,
	input  wire logic               master_reset_drive_n,
	input  wire logic               prefetch_req,
	input  wire logic [12:0]        prefetch_addr,
	input  wire logic               vector_req,
	input  wire logic [12:0]        vector_addr,
	input  wire swc_pkg::swc_port_s port_out
);
	wire entry = sleep_exec && !core_hold && !device_reset;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_entry; entry |=> !power_down_flag && timeout_flag && !osc_driver_on && watchdog_clear && core_hold;
	endproperty
	a_entry: assert property (p_entry) else $error("entry");
	property p_fetch; entry |=> prefetch_req && prefetch_addr == $past(pc) + 13'h1; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch");
	property p_pin; master_reset_drive_n; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_ports; core_hold && $past(core_hold) |-> $stable(port_out); endproperty
	a_ports: assert property (p_ports) else $error("ports");
	property p_vec; vector_req |-> vector_addr == 13'h4 && $fell(core_hold); endproperty
	a_vec: assert property (p_vec) else $error("vector");
	property p_pd; $fell(power_down_flag) |-> $rose(core_hold); endproperty
	a_pd: assert property (p_pd) else $error("pd");
	property p_rc; watchdog_clear && $past(core_hold) && osc_mode == 2'h3 |-> ##2 !core_hold; endproperty
	a_rc: assert property (p_rc) else $error("rc");
	property p_osc; !osc_driver_on |-> core_hold; endproperty
	a_osc: assert property (p_osc) else $error("osc");
	property p_to; $fell(timeout_flag) |-> watchdog_clear && core_hold; endproperty
	a_to: assert property (p_to) else $error("timeout flag");
endmodule : swc_props
bind swc_sleep_wakeup_control swc_props u_props (
	.clk                  (clk),
	.nrst                 (nrst),
	.sleep_exec           (sleep_exec),
	.osc_mode             (osc_mode),
	.pc                   (pc),
	.power_down_flag      (power_down_flag),
	.timeout_flag         (timeout_flag),
	.osc_driver_on        (osc_driver_on),
	.watchdog_clear       (watchdog_clear),
	.core_hold            (core_hold),
	.device_reset         (device_reset),
	.master_reset_drive_n (master_reset_drive_n),
	.prefetch_req         (prefetch_req),
	.prefetch_addr        (prefetch_addr),
	.vector_req           (vector_req),
	.vector_addr          (vector_addr),
	.port_out             (port_out)
);
`default_nettype wire

//--- verif/test_swc_sleep_wakeup_control.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module test_swc_sleep_wakeup_control;
	logic clk = 1'h0, nrst = 1'h0, sleep_exec = 1'h0, fire = 1'h0, clrwdt_exec = 1'h0, watchdog_enable = 1'h1;
	logic master_reset_pin_n = 1'h1, global_irq_enable = 1'h0, watchdog_timeout, power_down_flag, timeout_flag;
	logic osc_driver_on, watchdog_clear, core_hold, device_reset, master_reset_drive_n, prefetch_req, vector_req;
	logic [12:0] pc = 13'h1ffe, prefetch_addr, vector_addr;
	logic [1:0] osc_mode = 2'h3;
	swc_pkg::swc_irq_s irq = 6'h0;
	swc_pkg::swc_port_s port_in = 26'h2a5c3f1, port_out;
	int bad_count = 0, check_count = 0;
	always #12.5 clk = ~clk;
	swc_sleep_wakeup_control DUT (
		.clk                  (clk),
		.nrst                 (nrst),
		.sleep_exec           (sleep_exec),
		.pc                   (pc),
		.global_irq_enable    (global_irq_enable),
		.irq                  (irq),
		.osc_mode             (osc_mode),
		.clrwdt_exec          (clrwdt_exec),
		.master_reset_pin_n   (master_reset_pin_n),
		.watchdog_enable      (watchdog_enable),
		.watchdog_timeout     (watchdog_timeout),
		.port_in              (port_in),
		.power_down_flag      (power_down_flag),
		.timeout_flag         (timeout_flag),
		.osc_driver_on        (osc_driver_on),
		.watchdog_clear       (watchdog_clear),
		.core_hold            (core_hold),
		.device_reset         (device_reset),
		.master_reset_drive_n (master_reset_drive_n),
		.prefetch_req         (prefetch_req),
		.prefetch_addr        (prefetch_addr),
		.vector_req           (vector_req),
		.vector_addr          (vector_addr),
		.port_out             (port_out)
	);
	swc_wdog_model u_wd (
		.clk              (clk),
		.fire             (fire),
		.watchdog_timeout (watchdog_timeout)
	);
	task automatic chk(input logic [25:0] got, want);
		check_count++;
		if (got !== want) begin
			bad_count++;
			$display("mismatch %0t %h %h", $time, got, want);
		end
	endtask : chk
	task automatic end_sim;
		if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Wake cause c: 0 irq, 1 watchdog, 2 irq already pending, 3 watchdog while disabled then irq
	task automatic nap(input logic [1:0] m, input logic g, input int c);
		int n = 0;
		logic w = 1'h0;
		{osc_mode, global_irq_enable, irq, sleep_exec} = {m, g, c == 2 ? 6'h09 : 6'h07, 1'h1};
		watchdog_enable = c != 3;
		@(negedge clk);
		{sleep_exec, port_in} = {1'h0, ~port_in};
		chk({power_down_flag, timeout_flag, osc_driver_on, core_hold, prefetch_req}, 5'hb);
		chk(prefetch_addr, 13'h1fff);
		repeat (4) begin
			@(negedge clk);
			w |= watchdog_clear;
		end
		chk({core_hold, osc_driver_on, prefetch_req}, {1'h1, c == 2, 1'h0});
		chk(port_out, ~port_in);
		{irq, fire} = {c[0] ? 6'h07 : 6'h0f, c[0]};
		if (c == 3) begin
			repeat (8) @(negedge clk);
			chk(core_hold, 1'h1);
			irq = 6'h0f;
		end
		while (core_hold === 1'h1 && n < 1100) begin
			@(negedge clk);
			n++;
			w |= watchdog_clear;
		end
		if (n == 1100) begin
			bad_count++;
			end_sim;
		end
		if (c == 0) chk(26'(n), m == 2'h3 ? 26'h3 : 26'h403);
		chk({vector_req, timeout_flag, w}, {c != 1 && g, c != 1, 1'h1});
		chk(vector_addr, 13'h4);
		{irq, fire, watchdog_enable} = 8'h01;
		@(negedge clk);
	endtask : nap
	task automatic pin_wake;
		{osc_mode, sleep_exec} = 3'h7;
		@(negedge clk);
		{sleep_exec, master_reset_pin_n} = 2'h0;
		repeat (4) @(negedge clk);
		chk({device_reset, core_hold, master_reset_drive_n}, 3'h5);
		master_reset_pin_n = 1'h1;
		repeat (4) @(negedge clk);
		chk(device_reset, 1'h0);
	endtask : pin_wake
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'h1;
		chk({power_down_flag, timeout_flag, master_reset_drive_n}, 3'h7);
		@(negedge clk);
		for (int i = 0; i < 4; i++) nap(i[1:0], 1'h1, 0);
		nap(2'h3, 1'h0, 0);
		nap(2'h1, 1'h0, 2);
		nap(2'h2, 1'h0, 1);
		chk({power_down_flag, timeout_flag}, 2'h0);
		clrwdt_exec = 1'h1;
		@(negedge clk);
		clrwdt_exec = 1'h0;
		chk({power_down_flag, timeout_flag}, 2'h3);
		nap(2'h3, 1'h1, 3);
		pin_wake;
		end_sim;
	end
endmodule : test_swc_sleep_wakeup_control
`default_nettype wire
